// ---- verilog/rrs_pkg.sv ----
// package: constants and types for the return / rotate / sleep execution block
package rrs_pkg;

   // ----------------------------------------------------------------
   // widths and operand limits
   // ----------------------------------------------------------------
   localparam int RRS_DATA_W = 8;
   localparam int RRS_FADDR_W = 7;
   localparam logic [6:0] RRS_FADDR_MAX = 7'h7F;
   localparam int RRS_PC_W_DEF = 13;

   // ----------------------------------------------------------------
   // clock and instruction cycle counts
   // ----------------------------------------------------------------
   localparam int RRS_CLK_PERIOD_NS = 10;
   localparam int RRS_RET_CYCLES = 2;
   localparam int RRS_ROT_CYCLES = 1;
   localparam int RRS_SYNC_STAGES = 2;

   // ----------------------------------------------------------------
   // values after reset and the watchdog clear value
   // ----------------------------------------------------------------
   localparam logic RRS_PD_N_RST = 1'b1;
   localparam logic RRS_TO_N_RST = 1'b1;
   localparam logic [7:0] RRS_DATA_RST = 8'h00;
   localparam logic [7:0] RRS_WDT_CLEAR_VAL = 8'h00;

   // ----------------------------------------------------------------
   // instruction selects and control states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      RRS_OP_NONE,
      RRS_OP_RETURN,
      RRS_OP_ROT_LEFT,
      RRS_OP_ROT_RIGHT,
      RRS_OP_SLEEP
   } rrs_op_t;

   typedef enum logic [1:0] {
      RRS_ST_RUN,
      RRS_ST_RET2,
      RRS_ST_SLEEP
   } rrs_state_t;

endpackage : rrs_pkg

// ---- verilog/rrs_rotate.sv ----
// rotate-through-carry datapath, purely combinational
`timescale 1ns/1ns
`default_nettype none
module rrs_rotate
   import rrs_pkg::*;
#(
   parameter int DATA_W = RRS_DATA_W
) (
   input wire logic [DATA_W-1:0] value_in,
   input wire logic carry_in,
   input wire logic dir_right,
   output logic [DATA_W-1:0] value_out,
   output logic carry_out
);

   // ----------------------------------------------------------------
   // rotate one place through the carry bit
   // ----------------------------------------------------------------
   // old carry fills the vacated end, the bit pushed out becomes carry
   always_comb begin
      if (dir_right) begin
         value_out = {carry_in, value_in[DATA_W-1:1]}; // RULE4
         carry_out = value_in[0];
      end else begin
         value_out = {value_in[DATA_W-2:0], carry_in}; // RULE3
         carry_out = value_in[DATA_W-1];
      end
   end

endmodule : rrs_rotate
`default_nettype wire

// ---- verilog/rrs_exec.sv ----
// execution unit for subroutine return, rotates through carry and sleep entry
//
// Function
// RULE1: return pops the hardware stack, loads its top into PC, two cycles, no flags.
// RULE2: rotates take a file address 0 to 127 and a one-bit destination.
// RULE3: left rotate: old carry into bit 0, bit 7 out to carry.
// RULE4: right rotate: old carry into bit 7, bit 0 out to carry.
// RULE5: destination 0 writes the working register, 1 writes the source file register.
// RULE6: left rotate is one word, one cycle, and updates only carry.
// RULE7: sleep clears the active-low power-down flag and sets the active-low time-out flag.
// RULE8: sleep clears the watchdog counter and its prescaler.
// RULE9: after sleep the instruction clock stops and execution halts.
// RULE10: right rotate is one word, one cycle, and updates only carry.
`timescale 1ns/1ns
`default_nettype none
module rrs_exec
   import rrs_pkg::*;
#(
   parameter int PC_W = RRS_PC_W_DEF
) (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic CE,
   input wire logic OP_VALID,
   input wire rrs_op_t OP_CODE,
   input wire logic [RRS_FADDR_W-1:0] FILE_ADDR,
   input wire logic DEST_SEL,
   input wire logic [RRS_DATA_W-1:0] FILE_RDATA,
   input wire logic CARRY_IN,
   input wire logic [PC_W-1:0] STACK_TOP_VALUE,
   input wire logic WAKE_EVENT,
   output logic OP_READY,
   output logic STACK_POP,
   output logic PC_LOAD,
   output logic [PC_W-1:0] PC_VALUE,
   output logic W_WE,
   output logic FILE_WE,
   output logic [RRS_FADDR_W-1:0] FILE_WADDR,
   output logic [RRS_DATA_W-1:0] RESULT_DATA,
   output logic CARRY_WE,
   output logic CARRY_OUT,
   output logic WATCHDOG_CLEAR,
   output logic [RRS_DATA_W-1:0] WATCHDOG_COUNTER_LOAD,
   output logic TIMEOUT_FLAG_N,
   output logic POWERDOWN_FLAG_N,
   output logic SLEEP_ACTIVE
);

   // ----------------------------------------------------------------
   // wake synchroniser
   // ----------------------------------------------------------------
   logic wake_meta_reg;
   logic wake_sync_reg;

   // wake arrives from the pin side, so it is retimed before use
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         wake_meta_reg <= 1'b0;
         wake_sync_reg <= 1'b0;
      end else if (CE) begin
         wake_meta_reg <= WAKE_EVENT;
         wake_sync_reg <= wake_meta_reg;
      end
   end

   // ----------------------------------------------------------------
   // issue decode
   // ----------------------------------------------------------------
   rrs_state_t state_reg;
   rrs_state_t state_next;
   logic take;
   logic take_ret;
   logic take_rot;
   logic take_sleep;
   logic [RRS_DATA_W-1:0] rot_value;
   logic rot_carry;

   // new work only in the run state; the second return cycle and sleep stall
   assign OP_READY = CE && (state_reg == RRS_ST_RUN);
   assign take = OP_VALID && OP_READY;
   assign take_ret = take && (OP_CODE == RRS_OP_RETURN);
   assign take_rot = take && ((OP_CODE == RRS_OP_ROT_LEFT) || (OP_CODE == RRS_OP_ROT_RIGHT));
   assign take_sleep = take && (OP_CODE == RRS_OP_SLEEP);
   assign SLEEP_ACTIVE = (state_reg == RRS_ST_SLEEP);

   rrs_rotate #(
      .DATA_W(RRS_DATA_W)
   ) u_rotate (
      .value_in(FILE_RDATA),
      .carry_in(CARRY_IN),
      .dir_right(OP_CODE == RRS_OP_ROT_RIGHT),
      .value_out(rot_value),
      .carry_out(rot_carry)
   );

   // ----------------------------------------------------------------
   // control state
   // ----------------------------------------------------------------
   // sleep is left only on a retimed wake; nothing issues meanwhile
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         RRS_ST_RUN: begin
            if (take_ret) begin
               state_next = RRS_ST_RET2; // RULE1
            end else if (take_sleep) begin
               state_next = RRS_ST_SLEEP; // RULE9
            end
         end
         RRS_ST_RET2: state_next = RRS_ST_RUN;
         RRS_ST_SLEEP: begin
            if (wake_sync_reg) begin
               state_next = RRS_ST_RUN;
            end
         end
         default: state_next = RRS_ST_RUN;
      endcase
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         state_reg <= RRS_ST_RUN;
      end else if (CE) begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------------------------------
   // write-back and program counter strobes
   // ----------------------------------------------------------------
   logic stack_pop_reg, stack_pop_next;
   logic pc_load_reg, pc_load_next;
   logic [PC_W-1:0] pc_value_reg, pc_value_next;
   logic w_we_reg, w_we_next;
   logic file_we_reg, file_we_next;
   logic [RRS_FADDR_W-1:0] file_waddr_reg, file_waddr_next;
   logic [RRS_DATA_W-1:0] result_reg, result_next;
   logic carry_we_reg, carry_we_next;
   logic carry_out_reg, carry_out_next;
   logic wdt_clear_reg, wdt_clear_next;
   logic pd_n_reg, pd_n_next;
   logic to_n_reg, to_n_next;

   // strobes last one cycle; data and flags hold until the next instruction that writes them
   // only sleep touches the status flags here; a watchdog expiry sets them elsewhere
   always_comb begin
      stack_pop_next = 1'b0;
      pc_load_next = 1'b0;
      pc_value_next = pc_value_reg;
      w_we_next = 1'b0;
      file_we_next = 1'b0;
      file_waddr_next = file_waddr_reg;
      result_next = result_reg;
      carry_we_next = 1'b0;
      carry_out_next = carry_out_reg;
      wdt_clear_next = 1'b0;
      pd_n_next = pd_n_reg;
      to_n_next = to_n_reg;
      if (take_ret) begin
         stack_pop_next = 1'b1; // RULE1
         pc_load_next = 1'b1;
         pc_value_next = STACK_TOP_VALUE;
      end
      if (take_rot) begin
         // 7-bit address port keeps the operand inside 0..127
         file_waddr_next = FILE_ADDR; // RULE2
         result_next = rot_value;
         w_we_next = !DEST_SEL; // RULE5
         file_we_next = DEST_SEL; // RULE5
         carry_we_next = 1'b1; // RULE6 RULE10
         carry_out_next = rot_carry;
      end
      if (take_sleep) begin
         wdt_clear_next = 1'b1; // RULE8
         pd_n_next = 1'b0; // RULE7
         to_n_next = 1'b1; // RULE7
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         stack_pop_reg <= 1'b0;
         pc_load_reg <= 1'b0;
         pc_value_reg <= '0;
         w_we_reg <= 1'b0;
         file_we_reg <= 1'b0;
         file_waddr_reg <= '0;
         result_reg <= RRS_DATA_RST;
         carry_we_reg <= 1'b0;
         carry_out_reg <= 1'b0;
         wdt_clear_reg <= 1'b0;
         pd_n_reg <= RRS_PD_N_RST;
         to_n_reg <= RRS_TO_N_RST;
      end else if (CE) begin
         stack_pop_reg <= stack_pop_next;
         pc_load_reg <= pc_load_next;
         pc_value_reg <= pc_value_next;
         w_we_reg <= w_we_next;
         file_we_reg <= file_we_next;
         file_waddr_reg <= file_waddr_next;
         result_reg <= result_next;
         carry_we_reg <= carry_we_next;
         carry_out_reg <= carry_out_next;
         wdt_clear_reg <= wdt_clear_next;
         pd_n_reg <= pd_n_next;
         to_n_reg <= to_n_next;
      end
   end

   assign STACK_POP = stack_pop_reg;
   assign PC_LOAD = pc_load_reg;
   assign PC_VALUE = pc_value_reg;
   assign W_WE = w_we_reg;
   assign FILE_WE = file_we_reg;
   assign FILE_WADDR = file_waddr_reg;
   assign RESULT_DATA = result_reg;
   assign CARRY_WE = carry_we_reg;
   assign CARRY_OUT = carry_out_reg;
   assign WATCHDOG_CLEAR = wdt_clear_reg;
   assign WATCHDOG_COUNTER_LOAD = RRS_WDT_CLEAR_VAL; // RULE8
   assign POWERDOWN_FLAG_N = pd_n_reg;
   assign TIMEOUT_FLAG_N = to_n_reg;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);

   sequence s_ret;
      OP_VALID && OP_READY && (OP_CODE == RRS_OP_RETURN);
   endsequence
   sequence s_rol;
      OP_VALID && OP_READY && (OP_CODE == RRS_OP_ROT_LEFT);
   endsequence
   sequence s_ror;
      OP_VALID && OP_READY && (OP_CODE == RRS_OP_ROT_RIGHT);
   endsequence
   sequence s_slp;
      OP_VALID && OP_READY && (OP_CODE == RRS_OP_SLEEP);
   endsequence
   sequence s_pop_done;
      STACK_POP && PC_LOAD && !CARRY_WE && !W_WE && !FILE_WE && !OP_READY;
   endsequence

   property p_ret_pop;
      s_ret |=> s_pop_done and (PC_VALUE == $past(STACK_TOP_VALUE));
   endproperty
   a_ret_pop: assert property (p_ret_pop) else $error("return did not pop into pc"); // RULE1
   property p_ret_len;
      s_ret ##1 CE |=> (OP_READY || !CE) && !STACK_POP;
   endproperty
   a_ret_len: assert property (p_ret_len) else $error("return not two cycles"); // RULE1
   property p_rol;
      s_rol |=> (RESULT_DATA == {$past(FILE_RDATA[6:0]), $past(CARRY_IN)})
         && (CARRY_OUT == $past(FILE_RDATA[7]));
   endproperty
   a_rol: assert property (p_rol) else $error("left rotate result wrong"); // RULE3
   property p_ror;
      s_ror |=> (RESULT_DATA == {$past(CARRY_IN), $past(FILE_RDATA[7:1])})
         && (CARRY_OUT == $past(FILE_RDATA[0]));
   endproperty
   a_ror: assert property (p_ror) else $error("right rotate result wrong"); // RULE4
   property p_dest;
      (s_rol or s_ror) |=> (FILE_WE == $past(DEST_SEL)) && (W_WE != $past(DEST_SEL))
         && (FILE_WADDR == $past(FILE_ADDR)) && (FILE_WADDR <= RRS_FADDR_MAX);
   endproperty
   a_dest: assert property (p_dest) else $error("rotate destination wrong"); // RULE5 RULE2
   property p_rol_one;
      s_rol |=> CARRY_WE && !STACK_POP && $stable(POWERDOWN_FLAG_N) && (OP_READY || !CE);
   endproperty
   a_rol_one: assert property (p_rol_one) else $error("left rotate not single cycle"); // RULE6
   property p_ror_one;
      s_ror |=> CARRY_WE && !PC_LOAD && $stable(TIMEOUT_FLAG_N) && (OP_READY || !CE);
   endproperty
   a_ror_one: assert property (p_ror_one) else $error("right rotate not single cycle"); // RULE10
   property p_slp_flags;
      s_slp |=> !POWERDOWN_FLAG_N && TIMEOUT_FLAG_N && !CARRY_WE;
   endproperty
   a_slp_flags: assert property (p_slp_flags) else $error("sleep flags wrong"); // RULE7
   property p_slp_wdt;
      s_slp |=> WATCHDOG_CLEAR && (WATCHDOG_COUNTER_LOAD == RRS_WDT_CLEAR_VAL);
   endproperty
   a_slp_wdt: assert property (p_slp_wdt) else $error("sleep left watchdog running"); // RULE8
   // a wake seen one cycle earlier is the only way back to run
   property p_slp_halt;
      s_slp |=> SLEEP_ACTIVE && !OP_READY ##1 (!OP_READY || $past(wake_sync_reg) || !CE);
   endproperty
   a_slp_halt: assert property (p_slp_halt) else $error("execution continued in sleep"); // RULE9

endmodule : rrs_exec
`default_nettype wire

// ---- sim/rrs_exec_tb.sv ----
// self-checking testbench for the return / rotate / sleep execution unit
`timescale 1ns/1ns
`default_nettype none
module rrs_exec_tb
   import rrs_pkg::*;
;
   localparam int PC_W = RRS_PC_W_DEF;
   // ----------------------------------------------------------------
   // stimulus and observed signals
   // ----------------------------------------------------------------
   logic clk, rst_b, ce, op_valid, dest_sel, carry_in, wake_event;
   rrs_op_t op_code;
   logic [RRS_FADDR_W-1:0] file_addr, file_waddr;
   logic [RRS_DATA_W-1:0] file_rdata, result_data, wd_load;
   logic [PC_W-1:0] stack_top, pc_value;
   logic op_ready, stack_pop, pc_load, w_we, file_we, carry_we, carry_out, wd_clear;
   logic to_n, pd_n, sleep_active;
   int fails = 0;
   int checked = 0;
   int cycles = 0;
   int seed, i, r, t;

   rrs_exec #(.PC_W(PC_W)) DUT (
      .CLK(clk), .RST_B(rst_b), .CE(ce), .OP_VALID(op_valid), .OP_CODE(op_code),
      .FILE_ADDR(file_addr), .DEST_SEL(dest_sel), .FILE_RDATA(file_rdata),
      .CARRY_IN(carry_in), .STACK_TOP_VALUE(stack_top), .WAKE_EVENT(wake_event),
      .OP_READY(op_ready), .STACK_POP(stack_pop), .PC_LOAD(pc_load), .PC_VALUE(pc_value),
      .W_WE(w_we), .FILE_WE(file_we), .FILE_WADDR(file_waddr), .RESULT_DATA(result_data),
      .CARRY_WE(carry_we), .CARRY_OUT(carry_out), .WATCHDOG_CLEAR(wd_clear),
      .WATCHDOG_COUNTER_LOAD(wd_load), .TIMEOUT_FLAG_N(to_n), .POWERDOWN_FLAG_N(pd_n),
      .SLEEP_ACTIVE(sleep_active)
   );

   // free-running 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // checking helpers
   // ----------------------------------------------------------------
   task automatic report_and_stop();
      $display("checks=%0d mismatches=%0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : report_and_stop

   // case inequality so an unknown never counts as a match
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // expected {carry, result} of a rotate through carry
   function automatic logic [8:0] rot_exp(input logic right, input logic [7:0] d,
                                          input logic c);
      rot_exp = right ? {d[0], c, d[7:1]} : {d[7], d[6:0], c};
   endfunction : rot_exp

   // hang guard: the whole sequence needs well under 2000 cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         fails++;
         report_and_stop();
      end
   end

   // ----------------------------------------------------------------
   // operation tasks; inputs change only at the falling edge
   // ----------------------------------------------------------------
   // valid is left high so operations can follow back to back
   task automatic issue(input rrs_op_t code, input logic [6:0] a, input logic d,
                        input logic [7:0] v, input logic c, input logic [PC_W-1:0] top);
      op_valid = 1'b1;
      op_code = code;
      file_addr = a;
      dest_sel = d;
      file_rdata = v;
      carry_in = c;
      stack_top = top;
      @(negedge clk);
   endtask : issue

   task automatic rot(input logic right, input logic [6:0] a, input logic d,
                      input logic [7:0] v, input logic c);
      logic [8:0] e;
      e = rot_exp(right, v, c);
      issue(right ? RRS_OP_ROT_RIGHT : RRS_OP_ROT_LEFT, a, d, v, c, '0);
      chk(result_data, e[7:0]);
      chk(carry_out, e[8]);
      chk({w_we, file_we}, {!d, d});
      chk(file_waddr, a);
      chk({carry_we, stack_pop, pc_load, wd_clear, op_ready}, 5'h11);
   endtask : rot

   task automatic ret(input logic [PC_W-1:0] top);
      issue(RRS_OP_RETURN, '0, 1'b0, 8'h00, 1'b0, top);
      chk({stack_pop, pc_load}, 2'h3);
      chk(pc_value, top);
      chk({carry_we, w_we, file_we, wd_clear, op_ready}, 5'h00);
      op_valid = 1'b0;
      @(negedge clk);
      chk({stack_pop, pc_load, op_ready}, 3'h1);
   endtask : ret

   // sleep, an offer refused while asleep, then wake
   task automatic sleep_wake();
      int n;
      issue(RRS_OP_SLEEP, '0, 1'b0, 8'h00, 1'b0, '0);
      chk({wd_clear, wd_load}, 9'h100);
      chk({to_n, pd_n}, 2'h2);
      chk({sleep_active, op_ready, carry_we}, 3'h4);
      issue(RRS_OP_ROT_LEFT, 7'h11, 1'b1, 8'h5A, 1'b1, '0);
      chk({sleep_active, w_we, file_we, carry_we, wd_clear}, 5'h10);
      op_valid = 1'b0;
      wake_event = 1'b1;
      n = 0;
      while (sleep_active === 1'b1 && n < 10) begin
         @(negedge clk);
         n++;
      end
      wake_event = 1'b0;
      chk({sleep_active, op_ready}, 2'h1);
   endtask : sleep_wake

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      seed = 21;
      ce = 1'b1;
      op_valid = 1'b0;
      op_code = RRS_OP_NONE;
      file_addr = '0;
      dest_sel = 1'b0;
      file_rdata = '0;
      carry_in = 1'b0;
      stack_top = '0;
      wake_event = 1'b0;
      rst_b = 1'b0;
      repeat (12) @(negedge clk);
      rst_b = 1'b1;
      chk({to_n, pd_n, sleep_active, op_ready}, 4'hD);
      // corner cases: address limits, both carries, both destinations
      rot(1'b0, 7'h00, 1'b0, 8'hE6, 1'b0);
      rot(1'b1, 7'h7F, 1'b1, 8'h01, 1'b1);
      rot(1'b1, 7'h7F, 1'b0, 8'h80, 1'b0);
      rot(1'b0, 7'h40, 1'b1, 8'h7F, 1'b1);
      ret(13'h1FFF);
      ret(13'h0000);
      sleep_wake();
      // flags keep their sleep values across a later rotate
      rot(1'b0, 7'h05, 1'b1, 8'h81, 1'b0);
      chk({to_n, pd_n}, 2'h2);
      // random mix, mostly back to back
      for (i = 0; i < 300; i++) begin
         r = $random(seed);
         t = $random(seed);
         case (r[1:0])
            2'd0, 2'd1: begin
               rot(r[0], r[14:8], r[23], r[22:15], r[24]);
            end
            2'd2: begin
               ret(t[PC_W-1:0]);
            end
            default: begin
               issue(RRS_OP_NONE, r[14:8], r[23], r[22:15], r[24], '0);
               chk({stack_pop, pc_load, w_we, file_we, carry_we, wd_clear}, 6'h00);
            end
         endcase
         // occasional stall with the clock enable low refuses the offer
         if (t[31:28] == 4'hF) begin
            op_valid = 1'b0;
            @(negedge clk);
            ce = 1'b0;
            issue(RRS_OP_ROT_RIGHT, 7'h22, 1'b0, 8'h33, 1'b1, '0);
            chk({op_ready, w_we, carry_we}, 3'h0);
            ce = 1'b1;
            op_valid = 1'b0;
            @(negedge clk);
            chk({op_ready, w_we, carry_we}, 3'h4);
         end
      end
      sleep_wake();
      report_and_stop();
   end
endmodule : rrs_exec_tb
`default_nettype wire
